// File: shared/fdp_pkg.sv
package fdp_pkg;

    // ====================================================================
    // Register map
    localparam logic [7:0] FDP_REG_FP_STATUS_CONTROL_REG = 8'h00;
    localparam logic [7:0] FDP_REG_STATUS = 8'h04;
    localparam logic [31:0] FDP_FP_STATUS_CONTROL_REG_RESET = 32'h00000000;
    localparam logic [31:0] FDP_FP_STATUS_CONTROL_REG_WMASK = 32'h001FFFFF;

    // ====================================================================
    // Status and control field positions
    localparam int FDP_RM_LSB = 0;
    localparam int FDP_FLAG_LSB = 2;
    localparam int FDP_EN_LSB = 7;
    localparam int FDP_CAUSE_LSB = 12;
    localparam int FDP_DN_BIT = 18;
    localparam int FDP_PR_BIT = 19;
    localparam int FDP_SZ_BIT = 20;
    // Bit index inside each flag, enable and cause group
    localparam int FDP_X_I = 0;
    localparam int FDP_X_U = 1;
    localparam int FDP_X_O = 2;
    localparam int FDP_X_V = 4;
    localparam int FDP_X_E = 5;
    localparam logic [1:0] FDP_RM_NEAREST = 2'h0;

    // ====================================================================
    // Number formats
    localparam logic [31:0] FDP_SNG_ZERO = 32'h00000000;
    localparam logic [31:0] FDP_SNG_ONE = 32'h3F800000;
    localparam logic [31:0] FDP_SNG_QNAN = 32'h7FBFFFFF;
    localparam logic [31:0] FDP_SNG_INF = 32'h7F800000;
    localparam logic [7:0] FDP_SNG_EXP_MAX = 8'hFF;
    localparam logic [7:0] FDP_SNG_BIAS = 8'h7F;
    localparam logic [10:0] FDP_DBL_BIAS = 11'h3FF;
    // Inner product datapath: kept product bits, dropped bits, rebias
    localparam int FDP_PM_W = 28;
    localparam int FDP_PM_DROP = 20;
    localparam logic [11:0] FDP_FIP_EXP_ADJ = 12'h099;

    // ====================================================================
    // Operations and outcomes
    typedef enum logic [2:0] {
        FDP_OP_NOP = 3'h0,
        FDP_OP_INNER = 3'h1,
        FDP_OP_COPY = 3'h2,
        FDP_OP_LD0 = 3'h3,
        FDP_OP_LD1 = 3'h4,
        FDP_OP_FLOAT_S = 3'h5,
        FDP_OP_FLOAT_D = 3'h6
    } fdp_op_t;

    typedef enum logic [1:0] {
        FDP_EXC_NONE = 2'h0,
        FDP_EXC_SLOT_DIS = 2'h1,
        FDP_EXC_DIS = 2'h2,
        FDP_EXC_ARITH = 2'h3
    } fdp_exc_t;

    typedef struct packed {
        logic valid;
        fdp_op_t op;
        logic in_delay_slot;
        logic unit_disabled;
        logic [3:0][31:0] vec_src;
        logic [3:0][31:0] vec_dst;
        logic [31:0] single_src;
        logic [31:0] comm_in;
    } fdp_req_t;

    typedef struct packed {
        logic valid;
        fdp_exc_t exc;
        logic illegal;
        logic wr_vec;
        logic [3:0][31:0] vec_data;
        logic wr_single;
        logic [31:0] single_data;
        logic wr_double;
        logic [63:0] double_data;
        logic wr_comm;
        logic [31:0] comm_data;
        logic wr_fp_status_control_reg;
    } fdp_resp_t;

endpackage : fdp_pkg

// File: src/fdp_fpu_exec.sv
// Overview of operation
// - Exception checks run in fixed order; first hit stops the instruction.
// - Disabled unit raises slot-disabled in delay slot, else unit-disabled, first.
// - Inner product multiplies four pairs, sums, writes destination element 3.
// - Flush off: denormals keep true value; no error condition ever.
// - Flush on: denormals become signed zero before any checks.
// - Invalid on signaling NaN, zero times infinity, opposite infinities without qNaN.
// - Opposite infinities means a positive and a negative infinite product.
// - Finite products can overflow the sum to signed infinity; infinite product only from an infinite operand.
// - Non-special inner product results always set inexact.
// - Any of inexact, underflow, overflow enables forces the arithmetic exception.
// - Invalid traps only when enabled; else cause recorded, quiet NaN returned.
// - NaN operand or zero times infinity gives NaN product and NaN result.
// - Sum: finite gives approximation, same-sign infinities that infinity, mix NaN.
// - Copy to communication register is bit exact; only the disabled checks signal.
// - Load-zero writes all-zero single after the disabled checks.
// - Load-one writes single 1.0 after the disabled checks.
// - Constant loads and single conversion need precision mode 0.
// - Double conversion needs precision 1, size 0; exact, rounding ignored.
// - Single conversion of signed word rounds to nearest in mode 0, truncates in all other modes.
// - Conversions never overflow or underflow; inexact only for single.
// - Inexact enable forces the exception on single conversion, even exact.
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps

module fdp_fpu_exec (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire fdp_pkg::fdp_req_t req_i,
    output fdp_pkg::fdp_resp_t resp_o,
    output logic [31:0] fp_status_control_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ====================================================================
    // State
    typedef struct packed {
        logic [31:0] fp_status_control_reg;
        logic [31:0] rdata;
        logic ack;
        fdp_pkg::fdp_exc_t last_exc;
        logic last_illegal;
        fdp_pkg::fdp_resp_t resp;
    } fdp_state_t;

    fdp_state_t st_reg;
    fdp_state_t st_next;

    // ====================================================================
    // Helpers
    // Denormal to signed zero when flushing is on
    function automatic logic [31:0] fdp_flush(input logic [31:0] x,
                                              input logic dn);
        if (dn && x[30:23] == 8'h00)
            return {x[31], 31'h00000000};
        return x;
    endfunction : fdp_flush

    function automatic logic fdp_is_nan(input logic [31:0] x);
        return x[30:23] == fdp_pkg::FDP_SNG_EXP_MAX && x[22:0] != 23'h000000;
    endfunction : fdp_is_nan

    function automatic logic fdp_is_snan(input logic [31:0] x);
        return fdp_is_nan(x) && x[22];
    endfunction : fdp_is_snan

    function automatic logic fdp_is_inf(input logic [31:0] x);
        return x[30:23] == fdp_pkg::FDP_SNG_EXP_MAX && x[22:0] == 23'h000000;
    endfunction : fdp_is_inf

    function automatic logic fdp_is_zero(input logic [31:0] x);
        return x[30:0] == 31'h00000000;
    endfunction : fdp_is_zero

    // Position of the leading one, zero for a zero input
    function automatic logic [4:0] fdp_msb(input logic [31:0] x);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (x[i])
                p = 5'(i);
        end
        return p;
    endfunction : fdp_msb

    // ====================================================================
    // Next-state logic: bus slave, instruction execution, status update
    always_comb
    begin
        logic [3:0][31:0] fa;
        logic [3:0][31:0] fb;
        logic [3:0][27:0] pm;
        logic [3:0][9:0] ep;
        logic [3:0] psign;
        logic [47:0] prod;
        logic [23:0] ma;
        logic [23:0] mb;
        logic [9:0] epm;
        logic [9:0] sh;
        logic [31:0] aligned;
        logic signed [31:0] sum;
        logic [31:0] mag;
        logic [31:0] norm;
        logic [4:0] p;
        logic [11:0] e_res;
        logic any_snan;
        logic any_qnan;
        logic prod_nan;
        logic zero_inf;
        logic pos_inf;
        logic neg_inf;
        logic nan_i;
        logic invalid;
        logic [31:0] ip_res;
        logic [5:0] cause;
        logic [4:0] en;
        logic dn;
        logic pr;
        logic sz;
        logic [1:0] rm;
        logic [31:0] cv_res;
        logic cv_guard;
        logic cv_sticky;
        logic cv_up;
        logic [31:0] fps;
        logic [31:0] wmerge;
        fa = '0;
        fb = '0;
        pm = '0;
        ep = '0;
        psign = '0;
        prod = '0;
        ma = '0;
        mb = '0;
        epm = '0;
        sh = '0;
        aligned = '0;
        sum = '0;
        mag = '0;
        norm = '0;
        p = '0;
        e_res = '0;
        any_snan = 1'b0;
        any_qnan = 1'b0;
        prod_nan = 1'b0;
        zero_inf = 1'b0;
        pos_inf = 1'b0;
        neg_inf = 1'b0;
        nan_i = 1'b0;
        invalid = 1'b0;
        ip_res = '0;
        cause = '0;
        cv_res = '0;
        cv_guard = 1'b0;
        cv_sticky = 1'b0;
        cv_up = 1'b0;
        wmerge = '0;
        fps = st_reg.fp_status_control_reg;
        en = fps[fdp_pkg::FDP_EN_LSB +: 5];
        dn = fps[fdp_pkg::FDP_DN_BIT];
        pr = fps[fdp_pkg::FDP_PR_BIT];
        sz = fps[fdp_pkg::FDP_SZ_BIT];
        rm = fps[fdp_pkg::FDP_RM_LSB +: 2];
        st_next = st_reg;
        st_next.resp = '0;

        // Wishbone slave: one wait state, ack drops after one cycle
        st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
        st_next.rdata = '0;
        if (wb_cyc_i && wb_stb_i && !st_reg.ack)
        begin
            for (int b = 0; b < 4; b++)
            begin
                wmerge[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8]
                                              : fps[8*b +: 8];
            end
            if (wb_adr_i == fdp_pkg::FDP_REG_FP_STATUS_CONTROL_REG)
            begin
                st_next.rdata = fps;
                if (wb_we_i)
                    st_next.fp_status_control_reg = wmerge & fdp_pkg::FDP_FP_STATUS_CONTROL_REG_WMASK;
            end
            else if (wb_adr_i == fdp_pkg::FDP_REG_STATUS)
                st_next.rdata = {29'h00000000, st_reg.last_illegal,
                                 st_reg.last_exc};
        end

        // Inner product: flush, classify and multiply each pair
        for (int i = 0; i < 4; i++)
        begin
            fa[i] = fdp_flush(req_i.vec_src[i], dn);
            fb[i] = fdp_flush(req_i.vec_dst[i], dn);
            any_snan = any_snan | fdp_is_snan(fa[i]) | fdp_is_snan(fb[i]);
            any_qnan = any_qnan | (fdp_is_nan(fa[i]) & !fdp_is_snan(fa[i]))
                | (fdp_is_nan(fb[i]) & !fdp_is_snan(fb[i]));
            nan_i = fdp_is_nan(fa[i]) | fdp_is_nan(fb[i]);
            if ((fdp_is_zero(fa[i]) && fdp_is_inf(fb[i]))
                || (fdp_is_inf(fa[i]) && fdp_is_zero(fb[i])))
            begin
                zero_inf = 1'b1;
                nan_i = 1'b1;
            end
            prod_nan = prod_nan | nan_i;
            psign[i] = fa[i][31] ^ fb[i][31];
            // Infinite product only from an infinite operand
            if (!nan_i && (fdp_is_inf(fa[i]) || fdp_is_inf(fb[i])))
            begin
                pos_inf = pos_inf | !psign[i];
                neg_inf = neg_inf | psign[i];
            end
            // Denormals keep their value: hidden bit clear, exponent one
            ma = {fa[i][30:23] != 8'h00, fa[i][22:0]};
            mb = {fb[i][30:23] != 8'h00, fb[i][22:0]};
            prod = ma * mb;
            pm[i] = prod[47 -: fdp_pkg::FDP_PM_W];
            if (!fdp_is_zero(fa[i]) && !fdp_is_zero(fb[i]))
                ep[i] = 10'((fa[i][30:23] == 8'h00 ? 8'h01 : fa[i][30:23]))
                    + 10'((fb[i][30:23] == 8'h00 ? 8'h01 : fb[i][30:23]));
            if (ep[i] > epm)
                epm = ep[i];
        end

        // Approximate sum aligned to the largest product exponent
        for (int i = 0; i < 4; i++)
        begin
            sh = epm - ep[i];
            if (sh < 10'(fdp_pkg::FDP_PM_W))
                aligned = {4'h0, pm[i]} >> sh;
            else
                aligned = '0;
            if (psign[i])
                sum = sum - $signed(aligned);
            else
                sum = sum + $signed(aligned);
        end
        mag = sum[31] ? 32'(-sum) : 32'(sum);
        p = fdp_msb(mag);
        norm = mag << (5'h1F - p);
        e_res = 12'(epm) + 12'(p) - fdp_pkg::FDP_FIP_EXP_ADJ;

        // Invalid: sNaN, zero times infinity, opposite infinities
        invalid = any_snan || zero_inf
            || (pos_inf && neg_inf && !any_qnan);
        if (prod_nan || (pos_inf && neg_inf))
            ip_res = fdp_pkg::FDP_SNG_QNAN;
        else if (pos_inf)
            ip_res = fdp_pkg::FDP_SNG_INF;
        else if (neg_inf)
            ip_res = {1'b1, fdp_pkg::FDP_SNG_INF[30:0]};
        else
        begin
            cause[fdp_pkg::FDP_X_I] = 1'b1;
            if (mag == 32'h00000000)
                ip_res = fdp_pkg::FDP_SNG_ZERO;
            else if ($signed(e_res) >= $signed(12'(fdp_pkg::FDP_SNG_EXP_MAX)))
            begin
                cause[fdp_pkg::FDP_X_O] = 1'b1;
                ip_res = {sum[31], fdp_pkg::FDP_SNG_INF[30:0]};
            end
            else if ($signed(e_res) <= $signed(12'h000))
            begin
                cause[fdp_pkg::FDP_X_U] = 1'b1;
                ip_res = {sum[31], 31'h00000000};
            end
            else
                ip_res = {sum[31], e_res[7:0], norm[30:8]};
        end
        if (invalid)
        begin
            cause = '0;
            cause[fdp_pkg::FDP_X_V] = 1'b1;
        end

        // Integer conversions: magnitude, normalise, round
        mag = req_i.comm_in[31] ? 32'(-req_i.comm_in) : req_i.comm_in;
        p = fdp_msb(mag);
        norm = mag << (5'h1F - p);
        cv_guard = norm[7];
        cv_sticky = norm[6:0] != 7'h00;
        cv_up = (rm == fdp_pkg::FDP_RM_NEAREST)
            && cv_guard && (cv_sticky || norm[8]);
        if (mag != 32'h00000000)
            cv_res = {req_i.comm_in[31],
                      8'(fdp_pkg::FDP_SNG_BIAS + 8'(p)), norm[30:8]}
                + 32'(cv_up);

        // Instruction execution, checks in priority order
        if (req_i.valid && req_i.op != fdp_pkg::FDP_OP_NOP)
        begin
            st_next.resp.valid = 1'b1;
            st_next.resp.vec_data = req_i.vec_dst;
            if (req_i.unit_disabled && req_i.in_delay_slot)
                st_next.resp.exc = fdp_pkg::FDP_EXC_SLOT_DIS;
            else if (req_i.unit_disabled)
                st_next.resp.exc = fdp_pkg::FDP_EXC_DIS;
            else
            begin
                unique case (req_i.op)
                    fdp_pkg::FDP_OP_INNER:
                    begin
                        st_next.fp_status_control_reg[fdp_pkg::FDP_CAUSE_LSB +: 6] = cause;
                        if (en[fdp_pkg::FDP_X_V] && invalid)
                            st_next.resp.exc = fdp_pkg::FDP_EXC_ARITH;
                        else if (en[fdp_pkg::FDP_X_I] || en[fdp_pkg::FDP_X_O]
                                 || en[fdp_pkg::FDP_X_U])
                            st_next.resp.exc = fdp_pkg::FDP_EXC_ARITH;
                        else
                        begin
                            st_next.resp.wr_vec = 1'b1;
                            st_next.resp.vec_data[3] = ip_res;
                            st_next.fp_status_control_reg[fdp_pkg::FDP_FLAG_LSB +: 5] =
                                st_next.fp_status_control_reg[fdp_pkg::FDP_FLAG_LSB +: 5]
                                | cause[4:0];
                        end
                        st_next.resp.wr_fp_status_control_reg = 1'b1;
                    end
                    fdp_pkg::FDP_OP_COPY:
                    begin
                        st_next.resp.wr_comm = 1'b1;
                        st_next.resp.comm_data = req_i.single_src;
                    end
                    fdp_pkg::FDP_OP_LD0, fdp_pkg::FDP_OP_LD1:
                    begin
                        if (pr)
                            st_next.resp.illegal = 1'b1;
                        else
                        begin
                            st_next.resp.wr_single = 1'b1;
                            st_next.resp.single_data =
                                (req_i.op == fdp_pkg::FDP_OP_LD1)
                                ? fdp_pkg::FDP_SNG_ONE
                                : fdp_pkg::FDP_SNG_ZERO;
                        end
                    end
                    fdp_pkg::FDP_OP_FLOAT_S:
                    begin
                        if (pr)
                            st_next.resp.illegal = 1'b1;
                        else
                        begin
                            cause = '0;
                            cause[fdp_pkg::FDP_X_I] =
                                cv_guard || cv_sticky;
                            st_next.fp_status_control_reg[fdp_pkg::FDP_CAUSE_LSB +: 6] = cause;
                            st_next.resp.wr_fp_status_control_reg = 1'b1;
                            if (en[fdp_pkg::FDP_X_I])
                                st_next.resp.exc = fdp_pkg::FDP_EXC_ARITH;
                            else
                            begin
                                st_next.resp.wr_single = 1'b1;
                                st_next.resp.single_data = cv_res;
                                st_next.fp_status_control_reg[fdp_pkg::FDP_FLAG_LSB
                                              + fdp_pkg::FDP_X_I] =
                                    st_next.fp_status_control_reg[fdp_pkg::FDP_FLAG_LSB
                                                  + fdp_pkg::FDP_X_I]
                                    | cause[fdp_pkg::FDP_X_I];
                            end
                        end
                    end
                    fdp_pkg::FDP_OP_FLOAT_D:
                    begin
                        if (!pr || sz)
                            st_next.resp.illegal = 1'b1;
                        else
                        begin
                            // Exact: 32 bits always fit the double fraction
                            st_next.resp.wr_double = 1'b1;
                            if (mag != 32'h00000000)
                                st_next.resp.double_data =
                                    {req_i.comm_in[31],
                                     11'(fdp_pkg::FDP_DBL_BIAS + 11'(p)),
                                     norm[30:0], 21'h000000};
                        end
                    end
                    default:
                        st_next.resp.illegal = 1'b1;
                endcase
            end
            st_next.last_exc = st_next.resp.exc;
            st_next.last_illegal = st_next.resp.illegal;
        end
    end

    // ====================================================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
            st_reg.fp_status_control_reg <= fdp_pkg::FDP_FP_STATUS_CONTROL_REG_RESET;
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from the state register
    assign resp_o = st_reg.resp;
    assign fp_status_control_o = st_reg.fp_status_control_reg;
    assign wb_dat_o = st_reg.rdata;
    assign wb_ack_o = st_reg.ack;

endmodule : fdp_fpu_exec

// File: tb/fdp_fpu_exec_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the floating-point execution block
module fdp_fpu_exec_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire fdp_pkg::fdp_req_t req_i,
    input wire fdp_pkg::fdp_resp_t resp_o,
    input wire logic [31:0] fp_status_control_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    logic go;
    logic pr;
    logic ien;
    // Enabled request and mode bits
    assign go = req_i.valid && !req_i.unit_disabled;
    assign pr = fp_status_control_o[19];
    assign ien = fp_status_control_o[7];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_answer;
        req_i.valid && req_i.op != fdp_pkg::FDP_OP_NOP |=> resp_o.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_slot;
        req_i.valid && req_i.unit_disabled && req_i.in_delay_slot
        |=> resp_o.exc == fdp_pkg::FDP_EXC_SLOT_DIS && !resp_o.wr_vec;
    endproperty
    a_slot: assert property (p_slot) else $error("slot code");
    property p_dis;
        req_i.valid && req_i.unit_disabled && !req_i.in_delay_slot
        |=> resp_o.exc == fdp_pkg::FDP_EXC_DIS && !resp_o.wr_single;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled code");
    property p_copy;
        go && req_i.op == fdp_pkg::FDP_OP_COPY |=> resp_o.wr_comm
        && resp_o.comm_data == $past(req_i.single_src) && resp_o.exc == 0;
    endproperty
    a_copy: assert property (p_copy) else $error("copy data");
    property p_ld1;
        go && req_i.op == fdp_pkg::FDP_OP_LD1 && !pr
        |=> resp_o.wr_single && resp_o.single_data == 32'h3F800000;
    endproperty
    a_ld1: assert property (p_ld1) else $error("load one");
    property p_mode;
        go && !req_i.op[2] && req_i.op[1:0] == 2'h3 && pr
        |=> resp_o.illegal && !resp_o.wr_single;
    endproperty
    a_mode: assert property (p_mode) else $error("mode check");
    property p_keep;
        go && req_i.op == fdp_pkg::FDP_OP_INNER |=> !resp_o.wr_vec
        || resp_o.vec_data[2:0] == $past(req_i.vec_dst[2:0]);
    endproperty
    a_keep: assert property (p_keep) else $error("vector kept");
    property p_trap;
        go && req_i.op == fdp_pkg::FDP_OP_INNER && ien
        |=> resp_o.exc == fdp_pkg::FDP_EXC_ARITH;
    endproperty
    a_trap: assert property (p_trap) else $error("forced trap");
    property p_flti;
        go && req_i.op == fdp_pkg::FDP_OP_FLOAT_S && !pr && ien
        |=> resp_o.exc == fdp_pkg::FDP_EXC_ARITH && !resp_o.wr_single;
    endproperty
    a_flti: assert property (p_flti) else $error("float trap");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack");
    c_inner: cover property (go && req_i.op == fdp_pkg::FDP_OP_INNER);
    c_trap: cover property (resp_o.exc == fdp_pkg::FDP_EXC_ARITH);
    c_dbl: cover property (resp_o.wr_double);
endmodule : fdp_fpu_exec_asserts

// File: tb/fdp_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Core issue side: operand registers and one-shot issue
module fdp_core_model (
    input wire logic clk_i,
    input wire fdp_pkg::fdp_resp_t resp_i,
    output fdp_pkg::fdp_req_t req_o
);
    logic [3:0][31:0] va = '0;
    logic [3:0][31:0] vb = '0;
    logic [31:0] fr = '0;
    logic [31:0] comm = '0;
    initial req_o = '0;
    // One-cycle request, answer taken next edge
    task automatic issue(input fdp_pkg::fdp_op_t op, input logic slot,
        input logic dis, output fdp_pkg::fdp_resp_t r);
        req_o <= {1'b1, op, slot, dis, va, vb, fr, comm};
        @(posedge clk_i);
        req_o <= '0;
        @(posedge clk_i);
        r = resp_i;
    endtask : issue
endmodule : fdp_core_model

// File: tb/fdp_fpu_exec_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("FAIL %0t got %h", $time, (a)); end end
// ==========================================================
// Bench for the floating-point execution block
module fdp_fpu_exec_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rd;
    logic [31:0] fp;
    logic [31:0] wdo;
    logic ack;
    logic [3:0] sel = 4'hF;
    int errors = 0;
    int checks = 0;
    fdp_pkg::fdp_req_t req;
    fdp_pkg::fdp_resp_t rsp;
    fdp_pkg::fdp_resp_t r;
    initial forever #10 clk_i = ~clk_i;
    fdp_core_model core (.clk_i(clk_i), .resp_i(rsp), .req_o(req));
    fdp_fpu_exec dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .resp_o(rsp), .fp_status_control_o(fp), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wdo), .wb_ack_o(ack));
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Classic single bus cycle, data taken at the ack edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        rd = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40)
        begin
            errors++;
            give_verdict();
        end
        @(posedge clk_i);
    endtask : bus
    task automatic test_regs;
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h00000000)
        bus(1'b1, 8'h00, 32'hFFFFFFFF);
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h001FFFFF)
        sel <= 4'h1;
        bus(1'b1, 8'h00, 32'h0);
        sel <= 4'hF;
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h001FFF00)
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h00000000)
        $display("test regs done");
    endtask : test_regs
    task automatic test_dis;
        bus(1'b1, 8'h00, 32'h00000880);
        for (int i = 1; i < 7; i++)
        begin
            core.issue(fdp_pkg::fdp_op_t'(i), 1'b1, 1'b1, r);
            `CHK(r.exc, fdp_pkg::FDP_EXC_SLOT_DIS)
            core.issue(fdp_pkg::fdp_op_t'(i), 1'b0, 1'b1, r);
            `CHK(r.exc, fdp_pkg::FDP_EXC_DIS)
        end
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00000002)
        $display("test disabled done");
    endtask : test_dis
    task automatic test_const;
        bus(1'b1, 8'h00, 32'h0);
        core.fr = 32'hDEADBEEF;
        core.issue(fdp_pkg::FDP_OP_COPY, 1'b0, 1'b0, r);
        `CHK({r.exc, r.comm_data}, {2'h0, 32'hDEADBEEF})
        core.issue(fdp_pkg::FDP_OP_LD0, 1'b0, 1'b0, r);
        `CHK({r.wr_single, r.single_data}, 33'h100000000)
        core.issue(fdp_pkg::FDP_OP_LD1, 1'b0, 1'b0, r);
        `CHK(r.single_data, 32'h3F800000)
        bus(1'b1, 8'h00, 32'h00080000);
        core.issue(fdp_pkg::FDP_OP_LD1, 1'b0, 1'b0, r);
        `CHK({r.illegal, r.wr_single}, 2'h2)
        core.comm = 32'hFFFFFFFD;
        core.issue(fdp_pkg::FDP_OP_FLOAT_D, 1'b0, 1'b0, r);
        `CHK(r.double_data, 64'hC008000000000000)
        `CHK(r.exc, fdp_pkg::FDP_EXC_NONE)
        bus(1'b1, 8'h00, 32'h0);
        core.comm = 32'h01000003;
        core.issue(fdp_pkg::FDP_OP_FLOAT_S, 1'b0, 1'b0, r);
        `CHK(r.single_data, 32'h4B800002)
        bus(1'b1, 8'h00, 32'h00000001);
        core.issue(fdp_pkg::FDP_OP_FLOAT_S, 1'b0, 1'b0, r);
        `CHK(r.single_data, 32'h4B800001)
        bus(1'b1, 8'h00, 32'h00000080);
        core.comm = 32'h00000005;
        core.issue(fdp_pkg::FDP_OP_FLOAT_S, 1'b0, 1'b0, r);
        `CHK(r.exc, fdp_pkg::FDP_EXC_ARITH)
        $display("test convert done");
    endtask : test_const
    // Inner product cases
    task automatic inner(input logic [31:0] st, input logic [31:0] a0,
        input logic [31:0] a1, input logic [31:0] b0);
        bus(1'b1, 8'h00, st);
        core.va = {{2{32'h3F800000}}, a1, a0};
        core.vb = {{3{32'h40000000}}, b0};
        core.issue(fdp_pkg::FDP_OP_INNER, 1'b0, 1'b0, r);
    endtask : inner
    task automatic test_inner;
        inner(32'h0, 32'h3F800000, 32'h3F800000, 32'h40000000);
        `CHK(r.vec_data, {32'h41000000, core.vb[2:0]})
        `CHK(fp[2], 1'b1)
        inner(32'h0, 32'h7F800000, 32'hFF800000, 32'h40000000);
        `CHK(r.vec_data[3], 32'h7FBFFFFF)
        `CHK(fp[6], 1'b1)
        inner(32'h0, 32'h7FC00000, 32'h3F800000, 32'h40000000);
        `CHK(fp[6], 1'b1)
        inner(32'h0, 32'h7F800000, 32'h3F800000, 32'h40000000);
        `CHK(r.vec_data[3], 32'h7F800000)
        inner(32'h0, 32'h7F800000, 32'h3F800000, 32'h00000001);
        `CHK(r.vec_data[3], 32'h7F800000)
        inner(32'h00040000, 32'h7F800000, 32'h3F800000, 32'h00000001);
        `CHK(r.vec_data[3], 32'h7FBFFFFF)
        inner(32'h00040800, 32'h7F800000, 32'h3F800000, 32'h00000001);
        `CHK({r.exc, r.wr_vec}, {fdp_pkg::FDP_EXC_ARITH, 1'b0})
        inner(32'h00000080, 32'h3F800000, 32'h3F800000, 32'h40000000);
        `CHK(r.exc, fdp_pkg::FDP_EXC_ARITH)
        $display("test inner done");
    endtask : test_inner
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_regs();
        test_dis();
        test_const();
        test_inner();
        give_verdict();
    end
endmodule : fdp_fpu_exec_bench
bind fdp_fpu_exec fdp_fpu_exec_asserts u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .req_i(req_i), .resp_o(resp_o),
    .fp_status_control_o(fp_status_control_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
